// ---- core/sensor_fifo_cfg.svh ----
// Register offsets, field positions, reset values and frame constants of the sample FIFO
`ifndef SENSOR_FIFO_CFG_SVH
`define SENSOR_FIFO_CFG_SVH
`define OFS_CONFIG 8'h00
`define OFS_PIN_ONE_IO 8'h04
`define OFS_PIN_TWO_IO 8'h08
`define OFS_THR_LOW 8'h0c
`define OFS_THR_HIGH 8'h10
`define OFS_LEVEL_LOW 8'h14
`define OFS_LEVEL_HIGH 8'h18
`define OFS_DATA 8'h1c
`define OFS_STATUS 8'h20
`define OFS_ERROR 8'h24
`define OFS_CMD 8'h28
`define CFG_ACC_EN 0
`define CFG_AUX_EN 1
`define CFG_HDR_EN 2
`define CFG_STOP_FULL 3
`define CFG_TIME_EN 4
`define CFG_TAG1_EN 5
`define CFG_TAG2_EN 6
`define CFG_FILT 7
`define CFG_DOWNS_LSB 8
`define CFG_RESET 11'h084
`define CMD_FLUSH 8'hb0
`define FIFO_DEPTH 11'd1024
`define MAX_FRAME 11'd15
`define FULL_THR 11'd994
`define STG_BYTES 20
`define HDR_SKIP 8'h40
`define HDR_TIME 8'h44
`define HDR_INCFG 8'h48
`define HDR_DROP 8'h50
`define HDR_INVALID 8'h80
`endif

// ---- core/sensor_fifo_pkg.sv ----
// Types shared by the sample FIFO design
package sensor_fifo_pkg;
    typedef enum logic [1:0] {W_IDLE, W_ROOM, W_COPY} wr_state_type;
    typedef enum logic [1:0] {SRC_SKIP, SRC_DATA, SRC_TIME, SRC_OVER} rd_src_type;
endpackage

// ---- core/sensor_sample_fifo_frames.sv ----
// Sample FIFO of an acceleration sensor with framing, control frames and an APB register port
//
// Summary of operation
// - Frame rate follows fastest enabled sensor; unfiltered accel input runs at 1600 Hz.
// - Accel input to FIFO is down-sampled by two to the power k, k 0..7.
// - Overwrite mode discards oldest frames; header mode then prepends a skip frame.
// - Stop-when-full mode drops newest frame when free space under one max frame.
// - During host reads nothing is dropped at the tail; new data dropped, error flagged except in stop-when-full mode.
// - Control frames only in header mode; opcodes skip, sensortime, input-config, sample drop.
// - Fill level in bytes, low and high registers, stored control frames counted, skip and sensortime not.
// - Skip frame carries saturating skip count, leads next burst, takes no storage.
// - Optional sensortime frame ends a burst that empties the FIFO; takes no storage.
// - Filter configuration change inserts input-config frame before next data frame.
// - Input-config payload flags aux link, aux config, accel range, accel config writes.
// - Sample-drop payload: bit 2 aux dropped, bit 0 accel dropped.
// - Sample-drop frame after config frame only when no other sensor has a sample.
// - A partly read frame is delivered again whole on the next access.
// - Overreads return 0x8000 headerless or 0x0080 in header mode.
// - Frames combine all sensors sampled on the same tick of the common grid.
// - Enabled tag inputs set the two tag bits of each regular frame header.
// - Full event when fill level exceeds threshold two max frames before capacity.
// - Watermark event when fill level reaches the programmed threshold.
// - Full and watermark events suppressed while a data read burst is ongoing.
// - Latched event clears on status read only once the level is below threshold.
// - Command 0xb0 flushes; sensor toggle headerless, mode switch, aux size change flush too.
// - Storage holds 1024 bytes.
// - Header holds frame type, four-bit parameter and two tag bits.
// - Regular frame stored only with sensor data; aux bytes then accel X, Y, Z low first.
// - Headerless frames all share one size; size-changing configuration flushes.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "sensor_fifo_cfg.svh"
module sensor_sample_fifo_frames (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic accel_raw_tick,
    input wire logic accel_filt_tick,
    input wire logic [47:0] accel_xyz,
    input wire logic aux_tick,
    input wire logic [63:0] aux_bytes,
    input wire logic accel_dropped,
    input wire logic aux_dropped,
    input wire logic accel_config_changed,
    input wire logic accel_scale_changed,
    input wire logic secondary_config_changed,
    input wire logic secondary_link_changed,
    input wire logic [23:0] sensortime,
    input wire logic event_pin_one,
    input wire logic event_pin_two,
    output logic full_event,
    output logic watermark_event,
    output logic fifo_err
);
    logic [7:0] mem [0:1023];
    logic [10:0] cfg_q, cfg_d, wm_q, wm_d, count_q, count_d, free;
    logic pin1_q, pin1_d, pin2_q, pin2_d, full_q, full_d, wmk_q, wmk_d, err_q, err_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic take, wr_acc, data_rd, other_acc, st_rd, flush, acc_cfg_wr, hdr, err_set;
    logic [9:0] rd_ptr_q, rd_ptr_d, wr_ptr_q, wr_ptr_d;
    logic [4:0] idx_q, idx_d, widx_q, widx_d, wlen_q, wlen_d, hlen, stg_n;
    sensor_fifo_pkg::wr_state_type wst_q, wst_d;
    sensor_fifo_pkg::rd_src_type src_q, src_d, src;
    logic burst_q, burst_d, over_q, over_d, empt_q, empt_d, skpend_q, skpend_d, dwin_q, dwin_d;
    logic [7:0] skcnt_q, skcnt_d, cfgp_q, cfgp_d, rd_byte;
    logic [23:0] time_q, time_d;
    logic [6:0] ds_q, ds_d, ds_mask;
    logic [`STG_BYTES*8-1:0] stg, wbuf_q, wbuf_d;
    logic consume, dropold, commit, skip_inc, skip_clr, mem_we, acc_tick, acc_take, aux_take;
    logic [1:0] tags;

    function automatic logic [4:0] frame_len(input logic [7:0] h, input logic hm, input logic [10:0] c);
        logic [4:0] l;
        if (!hm) begin
            l = (c[`CFG_AUX_EN] ? 5'd8 : 5'd0) + (c[`CFG_ACC_EN] ? 5'd6 : 5'd0);
        end else if (h[7:6] == 2'b10) begin
            l = 5'd1 + (h[4] ? 5'd8 : 5'd0) + (h[2] ? 5'd6 : 5'd0);
        end else begin
            l = 5'd2;
        end
        return l;
    endfunction

    assign hdr = cfg_q[`CFG_HDR_EN];
    assign take = psel & penable & ~pready_q;
    assign wr_acc = take & pwrite;
    assign data_rd = take & ~pwrite & (paddr == `OFS_DATA);
    assign other_acc = take & (paddr != `OFS_DATA);
    assign st_rd = take & ~pwrite & (paddr == `OFS_STATUS);
    assign hlen = frame_len(mem[rd_ptr_q], hdr, cfg_q);
    assign free = `FIFO_DEPTH - count_q;

    // Register port: one wait state, side effects on the cycle prdata is loaded
    always_comb begin
        cfg_d = cfg_q;
        pin1_d = pin1_q;
        pin2_d = pin2_q;
        wm_d = wm_q;
        prdata_d = 32'h0000_0000;
        pslverr_d = 1'b0;
        pready_d = take;
        flush = 1'b0;
        acc_cfg_wr = 1'b0;
        err_d = err_q | err_set;
        if (wr_acc) begin
            case (paddr)
                `OFS_CONFIG: begin
                    cfg_d = pwdata[10:0];
                    acc_cfg_wr = pwdata[10:7] != cfg_q[10:7];
                    flush = (pwdata[`CFG_HDR_EN] != hdr) || (pwdata[`CFG_AUX_EN] != cfg_q[`CFG_AUX_EN])
                        || (!hdr && pwdata[`CFG_ACC_EN] != cfg_q[`CFG_ACC_EN]);
                end
                `OFS_PIN_ONE_IO: pin1_d = pwdata[0];
                `OFS_PIN_TWO_IO: pin2_d = pwdata[0];
                `OFS_THR_LOW: wm_d = {wm_q[10:8], pwdata[7:0]};
                `OFS_THR_HIGH: wm_d = {pwdata[2:0], wm_q[7:0]};
                `OFS_CMD: flush = pwdata[7:0] == `CMD_FLUSH;
                `OFS_LEVEL_LOW, `OFS_LEVEL_HIGH, `OFS_DATA, `OFS_STATUS, `OFS_ERROR: pslverr_d = 1'b0;
                default: pslverr_d = 1'b1;
            endcase
        end else if (take) begin
            case (paddr)
                `OFS_CONFIG: prdata_d = {21'h0, cfg_q};
                `OFS_PIN_ONE_IO: prdata_d = {31'h0, pin1_q};
                `OFS_PIN_TWO_IO: prdata_d = {31'h0, pin2_q};
                `OFS_THR_LOW: prdata_d = {24'h0, wm_q[7:0]};
                `OFS_THR_HIGH: prdata_d = {29'h0, wm_q[10:8]};
                `OFS_LEVEL_LOW: prdata_d = {24'h0, count_q[7:0]};
                `OFS_LEVEL_HIGH: prdata_d = {29'h0, count_q[10:8]};
                `OFS_DATA: prdata_d = {24'h0, rd_byte};
                `OFS_STATUS: prdata_d = {30'h0, wmk_q, full_q};
                `OFS_ERROR: begin
                    prdata_d = {31'h0, err_q};
                    err_d = err_set;
                end
                `OFS_CMD: prdata_d = 32'h0000_0000;
                default: pslverr_d = 1'b1;
            endcase
        end
        // Set wins over the conditional clear by a status read
        full_d = (!burst_q && count_q > `FULL_THR) || (full_q && !(st_rd && count_q <= `FULL_THR));
        wmk_d = (!burst_q && count_q >= wm_q) || (wmk_q && !(st_rd && count_q < wm_q));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= `CFG_RESET;
            pin1_q <= 1'b0;
            pin2_q <= 1'b0;
            wm_q <= 11'h000;
            full_q <= 1'b0;
            wmk_q <= 1'b0;
            err_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            pin1_q <= pin1_d;
            pin2_q <= pin2_d;
            wm_q <= wm_d;
            full_q <= full_d;
            wmk_q <= wmk_d;
            err_q <= err_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign full_event = full_q;
    assign watermark_event = wmk_q;
    assign fifo_err = err_q;

    // Frame assembly, writer with overflow policy, and reader
    always_comb begin
        int n;
        n = 0;
        stg = '0;
        acc_tick = cfg_q[`CFG_FILT] ? accel_filt_tick : accel_raw_tick;
        ds_mask = 7'((8'h01 << cfg_q[10:8]) - 8'h01);
        ds_d = acc_tick ? ds_q + 7'h01 : ds_q;
        acc_take = acc_tick && ((ds_q & ds_mask) == 7'h00) && cfg_q[`CFG_ACC_EN];
        aux_take = aux_tick && cfg_q[`CFG_AUX_EN];
        tags = {cfg_q[`CFG_TAG2_EN] & pin2_q & event_pin_two, cfg_q[`CFG_TAG1_EN] & pin1_q & event_pin_one};
        cfgp_d = hdr ? (cfgp_q | {2'b00, secondary_link_changed, secondary_config_changed, 2'b00,
            accel_scale_changed, accel_config_changed | acc_cfg_wr}) : 8'h00;
        dwin_d = dwin_q;
        if (wst_q == sensor_fifo_pkg::W_IDLE) begin
            if (hdr && cfgp_q != 8'h00 && (acc_take || aux_take || accel_dropped || aux_dropped)) begin
                stg[7:0] = `HDR_INCFG;
                stg[15:8] = cfgp_q;
                n = 2;
                cfgp_d = 8'h00;
                dwin_d = 1'b1;
            end
            if (hdr && (dwin_q || n != 0) && (accel_dropped || aux_dropped) && !acc_take && !aux_take) begin
                stg[n*8 +: 8] = `HDR_DROP;
                stg[(n+1)*8 +: 8] = {5'h00, aux_dropped, 1'b0, accel_dropped};
                n = n + 2;
            end
            if (acc_take || aux_take) begin
                dwin_d = 1'b0;
                if (hdr) begin
                    stg[n*8 +: 8] = {2'b10, 1'b0, aux_take, 1'b0, acc_take, tags};
                    n = n + 1;
                end
                for (int i = 0; i < 8; i++) begin
                    if (aux_take) begin
                        stg[(n+i)*8 +: 8] = aux_bytes[i*8 +: 8];
                    end
                end
                n = aux_take ? n + 8 : n;
                for (int i = 0; i < 6; i++) begin
                    if (acc_take) begin
                        stg[(n+i)*8 +: 8] = accel_xyz[i*8 +: 8];
                    end
                end
                n = acc_take ? n + 6 : n;
            end
        end
        stg_n = 5'(n);
        wst_d = wst_q;
        wlen_d = wlen_q;
        widx_d = widx_q;
        wbuf_d = wbuf_q;
        commit = 1'b0;
        dropold = 1'b0;
        skip_inc = 1'b0;
        mem_we = 1'b0;
        err_set = 1'b0;
        case (wst_q)
            sensor_fifo_pkg::W_IDLE: begin
                if (stg_n != 5'd0) begin
                    wbuf_d = stg;
                    wlen_d = stg_n;
                    wst_d = sensor_fifo_pkg::W_ROOM;
                end
            end
            sensor_fifo_pkg::W_ROOM: begin
                if (free < `MAX_FRAME || free < 11'(wlen_q)) begin
                    if (cfg_q[`CFG_STOP_FULL] || burst_q || data_rd) begin
                        skip_inc = 1'b1;
                        err_set = !cfg_q[`CFG_STOP_FULL];
                        wst_d = sensor_fifo_pkg::W_IDLE;
                    end else begin
                        dropold = 1'b1;
                        skip_inc = 1'b1;
                    end
                end else begin
                    widx_d = 5'd0;
                    wst_d = sensor_fifo_pkg::W_COPY;
                end
            end
            sensor_fifo_pkg::W_COPY: begin
                mem_we = 1'b1;
                widx_d = widx_q + 5'd1;
                if (widx_q == wlen_q - 5'd1) begin
                    commit = 1'b1;
                    wst_d = sensor_fifo_pkg::W_IDLE;
                end
            end
            default: wst_d = sensor_fifo_pkg::W_IDLE;
        endcase
        if (wst_q != sensor_fifo_pkg::W_IDLE && (acc_take || aux_take)) begin
            err_set = 1'b1;
        end
        src_d = src_q;
        idx_d = idx_q;
        burst_d = burst_q;
        over_d = over_q;
        empt_d = empt_q;
        time_d = time_q;
        rd_byte = 8'h00;
        consume = 1'b0;
        skip_clr = 1'b0;
        src = (!burst_q && hdr && skpend_q) ? sensor_fifo_pkg::SRC_SKIP : src_q;
        if (src == sensor_fifo_pkg::SRC_DATA && count_q == 11'd0) begin
            src = (hdr && cfg_q[`CFG_TIME_EN] && empt_q) ? sensor_fifo_pkg::SRC_TIME : sensor_fifo_pkg::SRC_OVER;
        end
        if (other_acc) begin
            // Ending the burst rewinds a partly read frame
            burst_d = 1'b0;
            idx_d = 5'd0;
            src_d = sensor_fifo_pkg::SRC_DATA;
            over_d = 1'b0;
            empt_d = 1'b0;
        end else if (data_rd) begin
            burst_d = 1'b1;
            case (src)
                sensor_fifo_pkg::SRC_SKIP: begin
                    rd_byte = idx_q[0] ? skcnt_q : `HDR_SKIP;
                    idx_d = idx_q[0] ? 5'd0 : 5'd1;
                    skip_clr = idx_q[0];
                    src_d = idx_q[0] ? sensor_fifo_pkg::SRC_DATA : sensor_fifo_pkg::SRC_SKIP;
                end
                sensor_fifo_pkg::SRC_DATA: begin
                    rd_byte = mem[rd_ptr_q + 10'(idx_q)];
                    idx_d = idx_q + 5'd1;
                    if (idx_q == hlen - 5'd1) begin
                        consume = 1'b1;
                        idx_d = 5'd0;
                        if (count_q == 11'(hlen)) begin
                            empt_d = 1'b1;
                            time_d = sensortime;
                        end
                    end
                end
                sensor_fifo_pkg::SRC_TIME: begin
                    rd_byte = (idx_q == 5'd0) ? `HDR_TIME : time_q[(idx_q-5'd1)*8 +: 8];
                    idx_d = idx_q + 5'd1;
                    if (idx_q == 5'd3) begin
                        idx_d = 5'd0;
                        src_d = sensor_fifo_pkg::SRC_OVER;
                        empt_d = 1'b0;
                    end
                end
                sensor_fifo_pkg::SRC_OVER: begin
                    rd_byte = (hdr ^ over_q) ? `HDR_INVALID : 8'h00;
                    over_d = ~over_q;
                end
                default: rd_byte = 8'h00;
            endcase
        end
        skcnt_d = skip_clr ? 8'h00 : skcnt_q;
        if (skip_inc && skcnt_d != 8'hff) begin
            skcnt_d = skcnt_d + 8'h01;
        end
        skpend_d = skip_inc || (skpend_q && !skip_clr);
        count_d = count_q + (commit ? 11'(wlen_q) : 11'd0) - ((consume || dropold) ? 11'(hlen) : 11'd0);
        rd_ptr_d = rd_ptr_q + ((consume || dropold) ? 10'(hlen) : 10'd0);
        wr_ptr_d = wr_ptr_q + (commit ? 10'(wlen_q) : 10'd0);
        if (flush) begin
            // Flush clears storage bookkeeping and pending skip, sensortime and drop state; pending input-config flags stay
            count_d = 11'd0;
            rd_ptr_d = 10'd0;
            wr_ptr_d = 10'd0;
            wst_d = sensor_fifo_pkg::W_IDLE;
            src_d = sensor_fifo_pkg::SRC_DATA;
            idx_d = 5'd0;
            skcnt_d = 8'h00;
            skpend_d = 1'b0;
            empt_d = 1'b0;
            dwin_d = 1'b0;
        end
    end

    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem[wr_ptr_q + 10'(widx_q)] <= wbuf_q[widx_q*8 +: 8];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 11'd0;
            rd_ptr_q <= 10'd0;
            wr_ptr_q <= 10'd0;
            wst_q <= sensor_fifo_pkg::W_IDLE;
            wlen_q <= 5'd0;
            widx_q <= 5'd0;
            wbuf_q <= '0;
            src_q <= sensor_fifo_pkg::SRC_DATA;
            idx_q <= 5'd0;
            burst_q <= 1'b0;
            over_q <= 1'b0;
            empt_q <= 1'b0;
            time_q <= 24'h000000;
            skcnt_q <= 8'h00;
            skpend_q <= 1'b0;
            cfgp_q <= 8'h00;
            dwin_q <= 1'b0;
            ds_q <= 7'h00;
        end else begin
            count_q <= count_d;
            rd_ptr_q <= rd_ptr_d;
            wr_ptr_q <= wr_ptr_d;
            wst_q <= wst_d;
            wlen_q <= wlen_d;
            widx_q <= widx_d;
            wbuf_q <= wbuf_d;
            src_q <= src_d;
            idx_q <= idx_d;
            burst_q <= burst_d;
            over_q <= over_d;
            empt_q <= empt_d;
            time_q <= time_d;
            skcnt_q <= skcnt_d;
            skpend_q <= skpend_d;
            cfgp_q <= cfgp_d;
            dwin_q <= dwin_d;
            ds_q <= ds_d;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence flush_cmd_s;
        wr_acc && paddr == `OFS_CMD && pwdata[7:0] == `CMD_FLUSH;
    endsequence
    sequence overread_hdr_s;
        data_rd && src == sensor_fifo_pkg::SRC_OVER && hdr && !over_q;
    endsequence

    chk_flush_empties: assert property (flush_cmd_s |=> count_q == 11'd0 && rd_ptr_q == 10'd0)
        else $error("flush command left data in the FIFO");
    chk_count_bound: assert property (count_q <= `FIFO_DEPTH)
        else $error("fill level above storage size");
    chk_full_hold: assert property ($rose(full_q) |-> !$past(burst_q))
        else $error("full event raised during a read burst");
    chk_full_level: assert property (!burst_q && count_q > `FULL_THR |=> full_q)
        else $error("full event missing above threshold");
    chk_wm_level: assert property (!burst_q && count_q >= wm_q && !wr_acc |=> wmk_q)
        else $error("watermark event missing");
    chk_no_tail_drop: assert property (burst_q && !consume && !flush |=> $stable(rd_ptr_q))
        else $error("tail moved during a read burst");
    chk_stop_keeps_old: assert property (cfg_q[`CFG_STOP_FULL] |-> !dropold)
        else $error("oldest frame dropped in stop mode");
    chk_overread_hdr: assert property (overread_hdr_s |=> prdata_q[7:0] == `HDR_INVALID && pready_q)
        else $error("header overread pattern wrong");
    chk_skip_sat: assert property (skcnt_q == 8'hff && !skip_clr && !flush |=> skcnt_q == 8'hff)
        else $error("skip count wrapped");
    chk_commit_whole: assert property (wst_q == sensor_fifo_pkg::W_COPY && !commit && !flush |=> $stable(wr_ptr_q))
        else $error("write pointer moved before frame complete");
endmodule

// ---- tb/apb_host.sv ----
// Host processor model: APB master that programs and drains the FIFO
`timescale 1ns/100ps
module apb_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Request held until pready is sampled high, so a slow answer is never cut short
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ---- tb/tb.sv ----
// Testbench: programs and drains the sample FIFO through the host model
`timescale 1ns/100ps
`include "sensor_fifo_cfg.svh"
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic accel_filt_tick = 1'b0;
    logic aux_tick = 1'b0;
    logic event_pin_one = 1'b1;
    logic [3:0] ch = 4'h0;
    logic [1:0] drop = 2'b00;
    logic [47:0] accel_xyz = 48'h0e0d0c0b0a09;
    logic [63:0] aux_bytes = 64'h0807060504030201;
    logic [23:0] sensortime = 24'h123456;
    logic full_event, watermark_event, fifo_err;
    int n_fail = 0;
    int n_tests = 0;

    always #2.5 pclk = ~pclk;

    sensor_sample_fifo_frames sensor_sample_fifo_frames_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .accel_raw_tick(accel_filt_tick), .accel_filt_tick(accel_filt_tick),
        .accel_xyz(accel_xyz), .aux_tick(aux_tick), .aux_bytes(aux_bytes),
        .accel_dropped(drop[0]), .aux_dropped(drop[1]),
        .accel_config_changed(ch[0]), .accel_scale_changed(ch[1]), .secondary_config_changed(ch[2]),
        .secondary_link_changed(ch[3]), .sensortime(sensortime), .event_pin_one(event_pin_one),
        .event_pin_two(1'b0), .full_event(full_event), .watermark_event(watermark_event), .fifo_err(fifo_err));

    apb_host apb_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    task summarize;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task check(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb_host_inst.xfer(1'b1, a, d, r, e);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb_host_inst.xfer(1'b0, a, 32'h0, r, e);
        check($sformatf("read %h", a), r, exp);
    endtask

    // Commit takes len+2 cycles; 20 idle cycles cover the longest frame
    task tick(input logic x);
        @(posedge pclk);
        accel_filt_tick <= 1'b1;
        aux_tick <= x;
        @(posedge pclk);
        accel_filt_tick <= 1'b0;
        aux_tick <= 1'b0;
        repeat (20) @(posedge pclk);
    endtask

    task drain;
        logic [111:0] pl;
        pl = {accel_xyz, aux_bytes};
        rd(`OFS_DATA, 32'h95);
        for (int i = 0; i < 14; i++)
            rd(`OFS_DATA, {24'h0, pl[8*i+:8]});
    endtask

    task t_reset;
        rd(`OFS_CONFIG, 32'h084);
        rd(`OFS_LEVEL_LOW, 32'h0);
        rd(8'h2c, 32'h0);
        check("error response", {31'h0, e}, 32'h1);
    endtask

    task t_frame;
        wr(`OFS_PIN_ONE_IO, 32'h1);
        wr(`OFS_CONFIG, 32'h0a7);
        tick(1'b1);
        rd(`OFS_LEVEL_LOW, 32'd15);
        drain;
        rd(`OFS_DATA, 32'h80);
        rd(`OFS_DATA, 32'h00);
    endtask

    task t_partial;
        tick(1'b1);
        rd(`OFS_DATA, 32'h95);
        rd(`OFS_DATA, 32'h01);
        rd(`OFS_LEVEL_LOW, 32'd15);
        drain;
    endtask

    task t_cfg;
        logic [7:0] flag [4];
        flag = '{8'h01, 8'h02, 8'h10, 8'h20};
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            ch[i] <= 1'b1;
            @(posedge pclk);
            ch[i] <= 1'b0;
            tick(1'b1);
            rd(`OFS_LEVEL_LOW, 32'd17);
            rd(`OFS_DATA, 32'h48);
            rd(`OFS_DATA, {24'h0, flag[i]});
            drain;
        end
    endtask

    // A lost sample with no data on that tick leaves a drop frame behind the config frame
    task t_drop;
        @(posedge pclk);
        ch[0] <= 1'b1;
        @(posedge pclk);
        ch[0] <= 1'b0;
        drop[1] <= 1'b1;
        @(posedge pclk);
        drop[1] <= 1'b0;
        repeat (20) @(posedge pclk);
        rd(`OFS_LEVEL_LOW, 32'd4);
        rd(`OFS_DATA, 32'h48);
        rd(`OFS_DATA, 32'h01);
        rd(`OFS_DATA, 32'h50);
        rd(`OFS_DATA, 32'h04);
    endtask

    task t_time;
        wr(`OFS_CONFIG, 32'h0b7);
        tick(1'b1);
        rd(`OFS_LEVEL_LOW, 32'd15);
        drain;
        rd(`OFS_DATA, 32'h44);
        rd(`OFS_DATA, 32'h56);
        rd(`OFS_DATA, 32'h34);
        rd(`OFS_DATA, 32'h12);
    endtask

    task t_mark;
        wr(`OFS_THR_LOW, 32'd15);
        rd(`OFS_STATUS, 32'h2);
        check("watermark idle", {31'h0, watermark_event}, 32'h0);
        tick(1'b1);
        check("watermark", {31'h0, watermark_event}, 32'h1);
        rd(`OFS_STATUS, 32'h2);
        check("watermark kept", {31'h0, watermark_event}, 32'h1);
        wr(`OFS_CMD, {24'h0, `CMD_FLUSH});
        rd(`OFS_LEVEL_LOW, 32'h0);
        rd(`OFS_STATUS, 32'h2);
        check("watermark cleared", {31'h0, watermark_event}, 32'h0);
    endtask

    // Boundary: 142 frames of 7 bytes sit exactly on the full threshold
    task t_full;
        wr(`OFS_CONFIG, 32'h085);
        repeat (142) tick(1'b0);
        check("full low", {31'h0, full_event}, 32'h0);
        tick(1'b0);
        check("full high", {31'h0, full_event}, 32'h1);
        rd(`OFS_LEVEL_HIGH, 32'h3);
        repeat (4) tick(1'b0);
        rd(`OFS_DATA, 32'h40);
        rd(`OFS_DATA, 32'h02);
        check("no error", {31'h0, fifo_err}, 32'h0);
        tick(1'b0);
        check("error flag", {31'h0, fifo_err}, 32'h1);
        rd(`OFS_ERROR, 32'h1);
        check("error cleared", {31'h0, fifo_err}, 32'h0);
        rd(`OFS_LEVEL_LOW, 32'hf7);
        wr(`OFS_CONFIG, 32'h08d);
        tick(1'b0);
        rd(`OFS_LEVEL_LOW, 32'hf7);
        check("stop no error", {31'h0, fifo_err}, 32'h0);
        rd(`OFS_DATA, 32'h40);
        rd(`OFS_DATA, 32'h02);
    endtask

    // Raw input at k=1 passes every second tick, so four ticks give two frames in any phase
    task t_down;
        wr(`OFS_CMD, {24'h0, `CMD_FLUSH});
        wr(`OFS_CONFIG, 32'h105);
        repeat (4) tick(1'b0);
        rd(`OFS_LEVEL_LOW, 32'd16);
        rd(`OFS_DATA, 32'h48);
        rd(`OFS_DATA, 32'h01);
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_frame;
        t_partial;
        t_cfg;
        t_drop;
        t_time;
        t_mark;
        t_full;
        t_down;
        summarize;
    end

    initial begin
        #100000;
        n_fail++;
        summarize;
    end
endmodule
